// >>> rbf_fifo.sv
// first-in first-out byte store held in flip-flops, show-ahead read
// assumes one clock, synchronous active-low reset and a clock enable;
// a write when full or a read when empty is ignored
`timescale 1ns/100ps
module rbf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  full,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [CW-1:0]    cnt;
    logic [AW-1:0]    next_wptr;
    logic [AW-1:0]    next_rptr;
    logic [CW-1:0]    next_cnt;
    logic             do_wr;
    logic             do_rd;

    assign full    = (cnt == CW'(DEPTH));
    assign empty   = (cnt == '0);
    assign rd_data = mem[rptr];
    assign do_wr   = wr_en && !full;
    assign do_rd   = rd_en && !empty;

    // pointers wrap at depth, so depth need not be a power of two
    always_comb begin
        next_mem  = mem;
        next_wptr = wptr;
        next_rptr = rptr;
        next_cnt  = cnt;
        if (do_wr) begin
            next_mem[wptr] = wr_data;
            next_wptr      = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
        end
        if (do_rd) begin
            next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
        end
        if (do_wr && !do_rd) begin
            next_cnt = cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_cnt = cnt - 1'b1;
        end
    end

    // storage is not reset, only the pointers and the count
    always_ff @(posedge clk_sys) begin
        if (ce) begin
            mem <= next_mem;
        end
        if (!rst_n) begin
            wptr <= '0;
            rptr <= '0;
            cnt  <= '0;
        end else if (ce) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            cnt  <= next_cnt;
        end
    end
endmodule

// >>> rbf_frame.sv
// digital baseband frame path: transmit buffer, preamble and delimiter,
// chip spreading; receive despreading, byte sync, buffer, crc, link quality
// assumes chips in and out one per enabled clock, converters outside,
// and a processor that reads and writes bytes by strobes
`timescale 1ns/100ps
`include "rbf_regs.svh"
module rbf_frame #(
    parameter int DEPTH = `RBF_BUF_DEPTH
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       tx_wr,
    input  wire logic [7:0] tx_wdata,
    input  wire logic       tx_start,
    output logic            tx_full,
    output logic            tx_busy,
    output logic            tx_chip,
    output logic            tx_chip_valid,
    output logic            tx_underflow,
    input  wire logic       rx_en,
    input  wire logic       rx_chip,
    input  wire logic       rx_chip_valid,
    input  wire logic [7:0] rssi,
    input  wire logic [7:0] cca_thresh,
    input  wire logic       rx_rd,
    output logic      [7:0] rx_rdata,
    output logic            rx_rvalid,
    output logic            rx_avail,
    output logic            rx_overflow,
    output logic            crc_ok,
    output logic            frame_done,
    output logic            irq_sfd,
    output logic            irq_cca
);
    // chip c0 sits in bit 31; symbol k of 1..7 rotates symbol 0 by 4k chips,
    // symbols 8..15 invert the odd chips of 0..7
    function automatic logic [31:0] chip_seq(input logic [3:0] sym);
        logic [63:0] dbl;
        logic [31:0] seq;
        dbl = {`RBF_CHIP_SEQ0, `RBF_CHIP_SEQ0} >> (4 * sym[2:0]);
        seq = dbl[31:0];
        return sym[3] ? (seq ^ `RBF_ODD_CHIPS) : seq;
    endfunction

    // agreement count between a chip window and one symbol sequence
    function automatic logic [5:0] corr_score(input logic [31:0] win, input logic [3:0] sym);
        logic [31:0] diff;
        logic [5:0]  n;
        diff = ~(win ^ chip_seq(sym));
        n    = '0;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'h00, diff[i]};
        end
        return n;
    endfunction

    // crc-16, reflected form, lsb first as bits go on air
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ `RBF_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // ---------------- transmit side ----------------
    rbf_pkg::rbf_tx_state_e tx_state;
    rbf_pkg::rbf_tx_state_e next_tx_state;
    logic [3:0]  cur_sym;
    logic [3:0]  next_cur_sym;
    logic [4:0]  chip_idx;
    logic [4:0]  next_chip_idx;
    logic [3:0]  sym_cnt;
    logic [3:0]  next_sym_cnt;
    logic        tx_half;
    logic        next_tx_half;
    logic [3:0]  tx_hold;
    logic [3:0]  next_tx_hold;
    logic [6:0]  tx_left;
    logic [6:0]  next_tx_left;
    logic        next_tx_underflow;
    logic        next_tx_chip;
    logic        next_tx_chip_valid;
    logic        tx_fetch;
    logic [31:0] cur_seq;
    logic        txf_pop;
    logic [7:0]  txf_data;
    logic        txf_full;
    logic        txf_empty;

    // transmit store is its own instance, never shared with receive
    rbf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .wr_en   (tx_wr),
        .wr_data (tx_wdata),
        .rd_en   (txf_pop),
        .rd_data (txf_data),
        .full    (txf_full),
        .empty   (txf_empty)
    );

    assign cur_seq = chip_seq(cur_sym);

    // symbol sequencer: preamble zeros, delimiter, then length and payload
    always_comb begin
        next_tx_state      = tx_state;
        next_cur_sym       = cur_sym;
        next_chip_idx      = chip_idx;
        next_sym_cnt       = sym_cnt;
        next_tx_half       = tx_half;
        next_tx_hold       = tx_hold;
        next_tx_left       = tx_left;
        next_tx_underflow  = tx_underflow;
        next_tx_chip       = 1'b0;
        next_tx_chip_valid = 1'b0;
        tx_fetch           = 1'b0;
        txf_pop            = 1'b0;
        case (tx_state)
            rbf_pkg::RBF_TX_IDLE: begin
                // a start with nothing buffered is ignored
                if (tx_start && !txf_empty) begin
                    next_tx_state     = rbf_pkg::RBF_TX_PRE;
                    next_cur_sym      = 4'h0;
                    next_chip_idx     = 5'h00;
                    next_sym_cnt      = 4'h0;
                    next_tx_underflow = 1'b0;
                end
            end
            default: begin
                next_tx_chip       = cur_seq[5'd31 - chip_idx];
                next_tx_chip_valid = 1'b1;
                next_chip_idx      = chip_idx + 5'd1;
                if (chip_idx == 5'd31) begin
                    case (tx_state)
                        rbf_pkg::RBF_TX_PRE: begin
                            if (sym_cnt == `RBF_PRE_SYMS - 4'd1) begin
                                next_tx_state = rbf_pkg::RBF_TX_SFD;
                                next_cur_sym  = 4'(`RBF_SFD_BYTE & 8'h0f);
                                next_tx_half  = 1'b1;
                            end else begin
                                next_sym_cnt = sym_cnt + 4'd1;
                            end
                        end
                        rbf_pkg::RBF_TX_SFD: begin
                            if (tx_half) begin
                                next_cur_sym = 4'(`RBF_SFD_BYTE >> 4);
                                next_tx_half = 1'b0;
                            end else begin
                                tx_fetch = 1'b1;
                            end
                        end
                        default: begin
                            if (tx_half) begin
                                next_cur_sym = tx_hold;
                                next_tx_half = 1'b0;
                            end else if (tx_left == 7'h00) begin
                                next_tx_state = rbf_pkg::RBF_TX_IDLE;
                            end else begin
                                tx_fetch = 1'b1;
                            end
                        end
                    endcase
                end
            end
        endcase
        // low nibble goes first; first byte after the delimiter is the length
        if (tx_fetch) begin
            if (txf_empty) begin
                next_tx_state     = rbf_pkg::RBF_TX_IDLE;
                next_tx_underflow = 1'b1;
            end else begin
                txf_pop       = 1'b1;
                next_tx_state = rbf_pkg::RBF_TX_DATA;
                next_cur_sym  = txf_data[3:0];
                next_tx_hold  = txf_data[7:4];
                next_tx_half  = 1'b1;
                next_tx_left  = (tx_state == rbf_pkg::RBF_TX_SFD) ? txf_data[6:0]
                                                                  : tx_left - 7'd1;
            end
        end
    end

    // transmit registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_state      <= rbf_pkg::RBF_TX_IDLE;
            cur_sym       <= 4'h0;
            chip_idx      <= 5'h00;
            sym_cnt       <= 4'h0;
            tx_half       <= 1'b0;
            tx_hold       <= 4'h0;
            tx_left       <= 7'h00;
            tx_underflow  <= 1'b0;
            tx_chip       <= 1'b0;
            tx_chip_valid <= 1'b0;
        end else if (ce) begin
            tx_state      <= next_tx_state;
            cur_sym       <= next_cur_sym;
            chip_idx      <= next_chip_idx;
            sym_cnt       <= next_sym_cnt;
            tx_half       <= next_tx_half;
            tx_hold       <= next_tx_hold;
            tx_left       <= next_tx_left;
            tx_underflow  <= next_tx_underflow;
            tx_chip       <= next_tx_chip;
            tx_chip_valid <= next_tx_chip_valid;
        end
    end

    // ---------------- receive side ----------------
    rbf_pkg::rbf_rx_state_e rx_state;
    rbf_pkg::rbf_rx_state_e next_rx_state;
    logic [31:0] win;
    logic [31:0] next_win;
    logic [4:0]  rx_cnt;
    logic [4:0]  next_rx_cnt;
    logic        rx_half;
    logic        next_rx_half;
    logic [3:0]  rx_lo;
    logic [3:0]  next_rx_lo;
    logic [6:0]  rx_left;
    logic [6:0]  next_rx_left;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [5:0]  corr_min;
    logic [5:0]  next_corr_min;
    logic        next_crc_ok;
    logic        next_frame_done;
    logic        next_irq_sfd;
    logic        next_rx_overflow;
    logic [3:0]  best_sym;
    logic [5:0]  best_score;
    logic [5:0]  sc;
    logic [7:0]  rx_byte;
    logic        rxf_push;
    logic [7:0]  rxf_wdata;
    logic        rxf_pop;
    logic [7:0]  rxf_data;
    logic        rxf_full;
    logic        rxf_empty;

    rbf_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxf (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .wr_en   (rxf_push),
        .wr_data (rxf_wdata),
        .rd_en   (rxf_pop),
        .rd_data (rxf_data),
        .full    (rxf_full),
        .empty   (rxf_empty)
    );

    assign next_win = rx_chip_valid ? {win[30:0], rx_chip} : win;

    // despreader: best of sixteen correlations over the newest 32 chips
    always_comb begin
        best_sym   = 4'h0;
        best_score = 6'h00;
        for (int s = 0; s < 16; s++) begin
            sc = corr_score(next_win, 4'(s));
            if (sc > best_score) begin
                best_sym   = 4'(s);
                best_score = sc;
            end
        end
    end

    assign rx_byte = {best_sym, rx_lo};

    // frame receiver; a weak symbol drops sync and abandons the frame
    always_comb begin
        next_rx_state    = rx_state;
        next_rx_cnt      = rx_cnt;
        next_rx_half     = rx_half;
        next_rx_lo       = rx_lo;
        next_rx_left     = rx_left;
        next_crc         = crc;
        next_corr_min    = corr_min;
        next_crc_ok      = crc_ok;
        next_rx_overflow = rx_overflow;
        next_frame_done  = 1'b0;
        next_irq_sfd     = 1'b0;
        rxf_push         = 1'b0;
        rxf_wdata        = rx_byte;
        case (rx_state)
            rbf_pkg::RBF_RX_HUNT: begin
                // chip alignment found on a strong preamble symbol
                if (rx_chip_valid && best_sym == 4'h0 && best_score >= `RBF_CORR_THRESH) begin
                    next_rx_state = rbf_pkg::RBF_RX_PRE;
                    next_rx_cnt   = 5'h00;
                end
            end
            rbf_pkg::RBF_RX_APP1: begin
                rxf_wdata     = rssi;
                rxf_push      = 1'b1;
                next_rx_state = rbf_pkg::RBF_RX_APP2;
            end
            rbf_pkg::RBF_RX_APP2: begin
                rxf_wdata       = {crc == `RBF_CRC_RESIDUE, 1'b0, corr_min};
                rxf_push        = 1'b1;
                next_crc_ok     = (crc == `RBF_CRC_RESIDUE);
                next_frame_done = 1'b1;
                next_rx_state   = rbf_pkg::RBF_RX_HUNT;
            end
            default: begin
                if (rx_chip_valid) begin
                    next_rx_cnt = rx_cnt + 5'd1;
                end
                if (rx_chip_valid && rx_cnt == 5'd31) begin
                    if (best_score < `RBF_CORR_THRESH) begin
                        next_rx_state = rbf_pkg::RBF_RX_HUNT;
                    end else if (rx_state == rbf_pkg::RBF_RX_PRE) begin
                        if (best_sym == (`RBF_SFD_BYTE & 8'h0f)) begin
                            next_rx_state = rbf_pkg::RBF_RX_SFD;
                        end else if (best_sym != 4'h0) begin
                            next_rx_state = rbf_pkg::RBF_RX_HUNT;
                        end
                    end else if (rx_state == rbf_pkg::RBF_RX_SFD) begin
                        if (best_sym == (`RBF_SFD_BYTE >> 4)) begin
                            next_rx_state    = rbf_pkg::RBF_RX_LEN;
                            next_irq_sfd     = 1'b1;
                            next_rx_half     = 1'b0;
                            next_crc         = `RBF_CRC_INIT;
                            next_corr_min    = `RBF_CORR_MAX;
                            next_rx_overflow = 1'b0;
                        end else begin
                            next_rx_state = rbf_pkg::RBF_RX_HUNT;
                        end
                    end else begin
                        if (best_score < corr_min) begin
                            next_corr_min = best_score;
                        end
                        if (!rx_half) begin
                            next_rx_lo   = best_sym;
                            next_rx_half = 1'b1;
                        end else begin
                            // byte complete: store it, a full buffer drops it
                            next_rx_half     = 1'b0;
                            rxf_push         = 1'b1;
                            next_rx_overflow = rx_overflow | rxf_full;
                            if (rx_state == rbf_pkg::RBF_RX_LEN) begin
                                next_rx_left  = rx_byte[6:0];
                                next_rx_state = (rx_byte[6:0] == 7'h00) ? rbf_pkg::RBF_RX_APP1
                                                                        : rbf_pkg::RBF_RX_DATA;
                            end else begin
                                next_crc     = crc_byte(crc, rx_byte);
                                next_rx_left = rx_left - 7'd1;
                                if (rx_left == 7'd1) begin
                                    next_rx_state = rbf_pkg::RBF_RX_APP1;
                                end
                            end
                        end
                    end
                end
            end
        endcase
        // leaving receive mode abandons any frame in progress, events included
        if (!rx_en) begin
            next_rx_state   = rbf_pkg::RBF_RX_HUNT;
            rxf_push        = 1'b0;
            next_irq_sfd    = 1'b0;
            next_frame_done = 1'b0;
            next_crc_ok     = crc_ok;
        end
    end

    // receive registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_state    <= rbf_pkg::RBF_RX_HUNT;
            win         <= 32'h00000000;
            rx_cnt      <= 5'h00;
            rx_half     <= 1'b0;
            rx_lo       <= 4'h0;
            rx_left     <= 7'h00;
            crc         <= `RBF_CRC_INIT;
            corr_min    <= `RBF_CORR_MAX;
            crc_ok      <= 1'b0;
            frame_done  <= 1'b0;
            irq_sfd     <= 1'b0;
            rx_overflow <= 1'b0;
        end else if (ce) begin
            rx_state    <= next_rx_state;
            win         <= next_win;
            rx_cnt      <= next_rx_cnt;
            rx_half     <= next_rx_half;
            rx_lo       <= next_rx_lo;
            rx_left     <= next_rx_left;
            crc         <= next_crc;
            corr_min    <= next_corr_min;
            crc_ok      <= next_crc_ok;
            frame_done  <= next_frame_done;
            irq_sfd     <= next_irq_sfd;
            rx_overflow <= next_rx_overflow;
        end
    end

    // ---------------- processor side ----------------
    logic [7:0] next_rx_rdata;
    logic       next_rx_rvalid;
    logic       next_irq_cca;

    // status flags lag the buffers by one cycle; writes into a full buffer are lost
    assign rxf_pop = rx_rd && !rxf_empty;
    always_comb begin
        next_rx_rdata  = rx_rdata;
        next_rx_rvalid = 1'b0;
        if (rxf_pop) begin
            next_rx_rdata  = rxf_data;
            next_rx_rvalid = 1'b1;
        end
        next_irq_cca = rx_en && (rssi < cca_thresh);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_rdata  <= 8'h00;
            rx_rvalid <= 1'b0;
            rx_avail  <= 1'b0;
            tx_full   <= 1'b0;
            tx_busy   <= 1'b0;
            irq_cca   <= 1'b0;
        end else if (ce) begin
            rx_rdata  <= next_rx_rdata;
            rx_rvalid <= next_rx_rvalid;
            rx_avail  <= !rxf_empty;
            tx_full   <= txf_full;
            // busy also spans the last chip, which leaves after the state goes idle
            tx_busy   <= (next_tx_state != rbf_pkg::RBF_TX_IDLE) || next_tx_chip_valid;
            irq_cca   <= next_irq_cca;
        end
    end
endmodule

// >>> rbf_frame_properties.sv
// port relations of the frame path, checked every rising edge
// assumes binding to rbf_frame; ce drops only while the frame paths are quiet
`timescale 1ns/100ps
module rbf_frame_properties (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       ce,
    input wire logic       tx_start,
    input wire logic       tx_busy,
    input wire logic       tx_chip_valid,
    input wire logic       tx_underflow,
    input wire logic       rx_en,
    input wire logic [7:0] rssi,
    input wire logic [7:0] cca_thresh,
    input wire logic       rx_rd,
    input wire logic       rx_rvalid,
    input wire logic       crc_ok,
    input wire logic       frame_done,
    input wire logic       irq_sfd,
    input wire logic       irq_cca
);
    logic cca_now;
    // channel clear condition seen at the inputs
    assign cca_now = rx_en && (rssi < cca_thresh);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // an accepted start: idle, pulse, then busy
    sequence s_go;
        !tx_busy && tx_start ##1 tx_busy;
    endsequence
    AST_GO: assert property (s_go |=> tx_chip_valid && !tx_underflow)
        else $error("start did not launch chips");
    AST_VALID_BUSY: assert property (tx_chip_valid |-> tx_busy)
        else $error("chip valid while idle");
    AST_BUSY_CAUSE: assert property ($rose(tx_busy) |-> $past(tx_start))
        else $error("busy rose without start");
    AST_SFD_PULSE: assert property (irq_sfd |=> !irq_sfd)
        else $error("delimiter pulse too long");
    AST_SFD_RX: assert property (irq_sfd |-> $past(rx_en))
        else $error("delimiter outside receive mode");
    AST_CCA: assert property ($past(rst_n) && $past(ce) |-> irq_cca == $past(cca_now))
        else $error("clear channel level wrong");
    AST_RD: assert property (rx_rvalid |-> $past(rx_rd))
        else $error("read data without read");
    AST_DONE: assert property (frame_done |=> !frame_done)
        else $error("frame done too long");
    AST_CRC_HOLD: assert property ($past(rst_n) && !frame_done |-> $stable(crc_ok))
        else $error("crc result moved between frames");
    AST_UNDER: assert property ($past(tx_underflow) && !$past(tx_start) |-> tx_underflow)
        else $error("underflow flag lost");
endmodule
bind rbf_frame rbf_frame_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .tx_start(tx_start), .tx_busy(tx_busy), .tx_chip_valid(tx_chip_valid),
    .tx_underflow(tx_underflow), .rx_en(rx_en), .rssi(rssi), .cca_thresh(cca_thresh),
    .rx_rd(rx_rd), .rx_rvalid(rx_rvalid), .crc_ok(crc_ok), .frame_done(frame_done),
    .irq_sfd(irq_sfd), .irq_cca(irq_cca));

// >>> rbf_peer.sv
// radio peer: carries transmitted chips back into the receiver
// assumes chips launched on rising edges, so falling edge is safe
`timescale 1ns/100ps
module rbf_peer (
    input  wire logic clk_sys,
    input  wire logic chip_in,
    input  wire logic valid_in,
    output logic      chip_out,
    output logic      valid_out
);
    initial begin
        chip_out = 1'b0;
        valid_out = 1'b0;
    end
    // outside frames the line toggles, so a stale chip never looks held
    always @(negedge clk_sys) begin
        valid_out <= valid_in;
        chip_out <= valid_in ? chip_in : ~chip_out;
    end
endmodule

// >>> rbf_pkg.sv
// types shared by the baseband frame path
// assumes nothing of its surroundings
package rbf_pkg;

    typedef enum logic [1:0] {
        RBF_TX_IDLE,
        RBF_TX_PRE,
        RBF_TX_SFD,
        RBF_TX_DATA
    } rbf_tx_state_e;

    typedef enum logic [2:0] {
        RBF_RX_HUNT,
        RBF_RX_PRE,
        RBF_RX_SFD,
        RBF_RX_LEN,
        RBF_RX_DATA,
        RBF_RX_APP1,
        RBF_RX_APP2
    } rbf_rx_state_e;

endpackage

// >>> rbf_regs.svh
// constants of the baseband frame path: frame layout, spreading and crc figures
// assumes the includer wants plain `define macros, no code
`ifndef RBF_REGS_SVH
`define RBF_REGS_SVH

`define RBF_BUF_DEPTH    128
`define RBF_PRE_SYMS     4'd8
`define RBF_SFD_BYTE     8'ha7
`define RBF_CHIP_SEQ0    32'hd9c3522e
`define RBF_ODD_CHIPS    32'h55555555
`define RBF_CORR_THRESH  6'd28
`define RBF_CORR_MAX     6'd32
`define RBF_CRC_POLY     16'h8408
`define RBF_CRC_INIT     16'h0000
`define RBF_CRC_RESIDUE  16'h0000

`endif

// >>> testbench.sv
// self-checking bench: tx frames looped back into rx through the peer
// assumes inputs change on falling edges; ce drops only in the cca test
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0, rst_n = 1'b0, tx_wr = 1'b0, tx_start = 1'b0, rx_en = 1'b0, rx_rd = 1'b0;
    logic ce = 1'b1;
    logic [7:0] tx_wdata = 8'h00, rssi = 8'h40, cca_thresh = 8'h00, rx_rdata;
    logic tx_full, tx_busy, tx_chip, tx_chip_valid, tx_underflow, rx_chip, rx_chip_valid;
    logic rx_rvalid, rx_avail, rx_overflow, crc_ok, frame_done, irq_sfd, irq_cca;
    int err_total = 0, check_count = 0, cyc = 0;
    rbf_frame #(.DEPTH(128)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .tx_wr(tx_wr), .tx_wdata(tx_wdata), .tx_start(tx_start), .tx_full(tx_full),
        .tx_busy(tx_busy), .tx_chip(tx_chip), .tx_chip_valid(tx_chip_valid),
        .tx_underflow(tx_underflow), .rx_en(rx_en), .rx_chip(rx_chip),
        .rx_chip_valid(rx_chip_valid), .rssi(rssi), .cca_thresh(cca_thresh), .rx_rd(rx_rd),
        .rx_rdata(rx_rdata), .rx_rvalid(rx_rvalid), .rx_avail(rx_avail),
        .rx_overflow(rx_overflow), .crc_ok(crc_ok), .frame_done(frame_done),
        .irq_sfd(irq_sfd), .irq_cca(irq_cca));
    rbf_peer u_peer (.clk_sys(clk_sys), .chip_in(tx_chip), .valid_in(tx_chip_valid),
        .chip_out(rx_chip), .valid_out(rx_chip_valid));
    // 100 ns period
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard well above the longest test
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            close_out();
        end
    end
    task automatic wr(input logic [7:0] b);
        @(negedge clk_sys) tx_wr = 1'b1;
        tx_wdata = b;
        @(negedge clk_sys) tx_wr = 1'b0;
    endtask
    // start, count chips until idle, in receive mode until frame done; keeps first 32 chips
    task automatic run(output int nv, output int ns, output logic [31:0] sh);
        int n;
        nv = 0;
        ns = 0;
        @(negedge clk_sys) tx_start = 1'b1;
        @(negedge clk_sys) tx_start = 1'b0;
        for (n = 0; n < 9000 && !frame_done && (tx_busy || rx_en || n < 3); n++) begin
            if (tx_chip_valid && nv < 32) sh = {sh[30:0], tx_chip};
            nv += tx_chip_valid;
            ns += irq_sfd;
            @(negedge clk_sys);
        end
    endtask
    // one strobe per byte, the way a dma channel would drain the buffer
    task automatic rd(input logic [7:0] exp, input logic ok);
        int n;
        @(negedge clk_sys) rx_rd = 1'b1;
        @(negedge clk_sys) rx_rd = 1'b0;
        for (n = 0; n < 3 && !rx_rvalid; n++) @(negedge clk_sys);
        chk("rx_rvalid", rx_rvalid, ok);
        if (ok) chk("rx_rdata", rx_rdata, exp);
    endtask
    // length 2 frame looped back; trailer gives rssi and crc flag with score 32
    task automatic t_frame(input logic [7:0] b1, input logic [7:0] t2, input logic ok);
        int nv, ns;
        logic [31:0] sh;
        rx_en = 1'b1;
        wr(8'h02);
        wr(b1);
        wr(8'h00);
        run(nv, ns, sh);
        chk("chips", nv, 32'd512);
        chk("sym0", sh, 32'hd9c3522e);
        chk("irq_sfd", ns, 32'd1);
        chk("crc_ok", crc_ok, ok);
        rd(8'h02, 1'b1);
        rd(b1, 1'b1);
        rd(8'h00, 1'b1);
        rd(rssi, 1'b1);
        rd(t2, 1'b1);
        rd(8'h00, 1'b0);
        $display("frame test done crc %0b", ok);
    endtask
    task automatic t_cca;
        rx_en = 1'b1;
        rssi = 8'h10;
        cca_thresh = 8'h20;
        repeat (2) @(negedge clk_sys);
        chk("irq_cca", irq_cca, 1'b1);
        // clock enable low freezes the level although the channel state moves
        ce = 1'b0;
        rx_en = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("irq_cca frozen", irq_cca, 1'b1);
        ce = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("irq_cca", irq_cca, 1'b0);
        rssi = 8'h40;
        $display("cca test done");
    endtask
    // fill tx buffer to 128, extra write refused, then a short frame runs dry
    task automatic t_tx;
        int i, nv, ns;
        logic [31:0] sh;
        rx_en = 1'b0;
        wr(8'h7f);
        for (i = 1; i < 129; i++) wr(i[7:0]);
        chk("tx_full", tx_full, 1'b1);
        run(nv, ns, sh);
        chk("chips full", nv, 32'd8512);
        chk("underflow", tx_underflow, 1'b0);
        wr(8'h03);
        wr(8'h11);
        run(nv, ns, sh);
        chk("underflow", tx_underflow, 1'b1);
        $display("tx buffer test done");
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        t_frame(8'h00, 8'ha0, 1'b1);
        t_frame(8'h01, 8'h20, 1'b0);
        t_cca();
        t_tx();
        close_out();
    end
endmodule
